// File: rtl/fsp_pkg.sv
package fsp_pkg;

    // ****************************************************************
    // Register map of the serial port.
    // ****************************************************************
    localparam logic [6:0] ADDR_SURFACE_QUALITY = 7'h05;
    localparam logic [6:0] ADDR_EXPOSURE_HIGH = 7'h06;
    localparam logic [6:0] ADDR_EXPOSURE_LOW = 7'h07;
    localparam logic [6:0] ADDR_BRIGHTEST_PIXEL = 7'h08;
    localparam logic [6:0] ADDR_FRAME_BRIGHTNESS_SUM = 7'h09;
    localparam logic [6:0] ADDR_DARKEST_PIXEL = 7'h0a;
    localparam logic [6:0] ADDR_FRAME_DUMP_PORT = 7'h0b;

    // ****************************************************************
    // Serial frame layout.
    // ****************************************************************
    localparam int WRITE_FLAG_BIT = 7;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    // ****************************************************************
    // Statistic limits and reset values.
    // ****************************************************************
    localparam logic [7:0] QUALITY_LIMIT = 8'ha7;
    localparam logic [7:0] EXTREME_LIMIT = 8'hfe;
    localparam logic [7:0] SUM_LIMIT = 8'hf0;
    localparam int SUM_SHIFT = 9;
    localparam logic [7:0] MIN_START = 8'hff;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // ****************************************************************
    // Pixel dump pointer.
    // ****************************************************************
    localparam logic [8:0] LAST_PIXEL = 9'h1e3;
    localparam logic [8:0] FIRST_PIXEL = 9'h000;

    // ****************************************************************
    // Exposure control loop.
    // ****************************************************************
    localparam logic [15:0] EXPOSURE_RESET = 16'h0100;
    localparam logic [15:0] EXPOSURE_STEP = 16'h0010;
    localparam logic [15:0] EXPOSURE_MIN = 16'h0010;
    localparam logic [15:0] EXPOSURE_MAX = 16'hffe0;
    localparam logic [7:0] BRIGHT_HIGH = 8'hf0;
    localparam logic [7:0] SUM_HIGH = 8'ha0;
    localparam logic [7:0] SUM_LOW = 8'h40;

    // Pixel stream from the image acquisition logic.
    typedef struct packed {
        logic pix_valid;
        logic [8:0] pix_index;
        logic [7:0] pix_value;
        logic frame_end;
        logic [8:0] feature_count;
    } fsp_frame_t;

    // Serial port phase.
    typedef enum logic [1:0] {
        SP_ADDR,
        SP_DATA_WR,
        SP_DATA_RD
    } fsp_phase_t;

endpackage

// File: rtl/fsp_frame_stats.sv
`timescale 1ns/10ps

// Function
// - Quality is upper eight of nine-bit count.
// - Quality recomputed from features every frame.
// - Quality register never exceeds 167.
// - Exposure sixteen bits, high and low bytes.
// - Exposure auto-adjusts from brightness each frame.
// - Brightest pixel 0 to 254, per frame.
// - Darkest pixel 0 to 254, per frame.
// - Sum register is frame sum divided 512.
// - Sum register kept between 0 and 240.
// - Dump delivers one pixel per frame.
// - Writing dump register resets pointer to zero.
// - Ready flag set only with valid byte.
// - Each dump read of a ready byte advances the pointer.
// - After full frame pointer wraps, first flag set.
// - Dump register write sets first flag.
// - Pointer covers pixels 0 through 483.
module fsp_frame_stats (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic NCS_N,
    input wire logic SCLK,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    input wire fsp_pkg::fsp_frame_t FRAME,
    output logic [15:0] EXPOSURE,
    output logic DUMP_BYTE_READY,
    output logic DUMP_FRAME_START
);

    // ****************************************************************
    // Helpers.
    // ****************************************************************

    // Saturate a statistic at its register ceiling.
    function automatic logic [7:0] clamp8(input logic [7:0] value, input logic [7:0] limit);
        clamp8 = (value > limit) ? limit : value;
    endfunction

    // ****************************************************************
    // Serial pin synchronisers.
    // ****************************************************************
    logic [2:0] sclk_ff;
    logic [1:0] mosi_ff;
    logic [1:0] ncs_ff;

    // The pins come from the controller's clock, so each passes two flops first.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sclk_ff <= 3'h7;
            mosi_ff <= 2'h0;
            ncs_ff <= 2'h3;
        end else begin
            sclk_ff <= {sclk_ff[1:0], SCLK};
            mosi_ff <= {mosi_ff[0], MOSI};
            ncs_ff <= {ncs_ff[0], NCS_N};
        end
    end

    wire logic sclk_rise = sclk_ff[1] & ~sclk_ff[2];
    wire logic sclk_fall = ~sclk_ff[1] & sclk_ff[2];
    wire logic selected = ~ncs_ff[1];
    wire logic mosi_bit = mosi_ff[1];

    // ****************************************************************
    // Serial port: address byte, then one data byte in or out.
    // ****************************************************************
    fsp_pkg::fsp_phase_t phase_ff;
    logic [2:0] bit_cnt_ff;
    logic [6:0] shift_in_ff;
    logic [6:0] addr_ff;
    logic [7:0] shift_out_ff;

    wire logic byte_done = selected & sclk_rise & (bit_cnt_ff == fsp_pkg::LAST_BIT_INDEX);
    wire logic [7:0] byte_in = {shift_in_ff, mosi_bit};
    wire logic addr_done = byte_done & (phase_ff == fsp_pkg::SP_ADDR);
    wire logic rd_start = addr_done & ~byte_in[fsp_pkg::WRITE_FLAG_BIT];
    wire logic wr_done = byte_done & (phase_ff == fsp_pkg::SP_DATA_WR);
    wire logic [6:0] rd_addr = byte_in[6:0];
    wire logic rd_dump = rd_start & (rd_addr == fsp_pkg::ADDR_FRAME_DUMP_PORT);
    wire logic rd_exp_high = rd_start & (rd_addr == fsp_pkg::ADDR_EXPOSURE_HIGH);
    wire logic wr_dump = wr_done & (addr_ff == fsp_pkg::ADDR_FRAME_DUMP_PORT);

    logic [7:0] surface_quality_ff;
    logic [7:0] brightest_pixel_ff;
    logic [7:0] darkest_pixel_ff;
    logic [7:0] frame_brightness_sum_ff;
    logic [7:0] dump_byte_ff;
    logic [7:0] exp_low_snap_ff;
    logic [15:0] exposure_ff;
    logic [7:0] rd_data;

    // Register read decode; unmapped addresses answer zero.
    always_comb begin
        unique case (rd_addr)
            fsp_pkg::ADDR_SURFACE_QUALITY: rd_data = surface_quality_ff;
            fsp_pkg::ADDR_EXPOSURE_HIGH: rd_data = exposure_ff[15:8];
            fsp_pkg::ADDR_EXPOSURE_LOW: rd_data = exp_low_snap_ff;
            fsp_pkg::ADDR_BRIGHTEST_PIXEL: rd_data = brightest_pixel_ff;
            fsp_pkg::ADDR_FRAME_BRIGHTNESS_SUM: rd_data = frame_brightness_sum_ff;
            fsp_pkg::ADDR_DARKEST_PIXEL: rd_data = darkest_pixel_ff;
            fsp_pkg::ADDR_FRAME_DUMP_PORT: rd_data = dump_byte_ff;
            default: rd_data = 8'h00;
        endcase
    end

    // Bits are sampled on the rising serial edge and shifted out on the falling one.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            phase_ff <= fsp_pkg::SP_ADDR;
            bit_cnt_ff <= 3'h0;
            shift_in_ff <= 7'h00;
            addr_ff <= 7'h00;
            shift_out_ff <= 8'h00;
        end else if (!selected) begin
            phase_ff <= fsp_pkg::SP_ADDR;
            bit_cnt_ff <= 3'h0;
        end else begin
            if (sclk_rise) begin
                shift_in_ff <= byte_in[6:0];
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (addr_done) begin
                addr_ff <= rd_addr;
                phase_ff <= byte_in[fsp_pkg::WRITE_FLAG_BIT] ? fsp_pkg::SP_DATA_WR
                                                              : fsp_pkg::SP_DATA_RD;
            end else if (byte_done) begin
                phase_ff <= fsp_pkg::SP_ADDR;
            end
            if (rd_start) begin
                shift_out_ff <= rd_data;
            end else if (sclk_fall && phase_ff == fsp_pkg::SP_DATA_RD) begin
                shift_out_ff <= {shift_out_ff[6:0], 1'b0};
            end
        end
    end

    // The output is released whenever the controller deselects the sensor.
    assign MISO = shift_out_ff[7];
    assign MISO_OE = selected;

    // ****************************************************************
    // Frame statistics.
    // ****************************************************************
    logic [7:0] acc_max_ff;
    logic [7:0] acc_min_ff;
    logic [16:0] acc_sum_ff;

    wire logic [7:0] nxt_brightest = clamp8(acc_max_ff, fsp_pkg::EXTREME_LIMIT);
    wire logic [7:0] nxt_darkest = clamp8(acc_min_ff, fsp_pkg::EXTREME_LIMIT);
    wire logic [7:0] nxt_sum = clamp8(acc_sum_ff[16:fsp_pkg::SUM_SHIFT], fsp_pkg::SUM_LIMIT);
    wire logic [7:0] nxt_quality = clamp8(FRAME.feature_count[8:1], fsp_pkg::QUALITY_LIMIT);

    // Accumulators restart at every frame end; a pixel must not share that cycle.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            acc_max_ff <= fsp_pkg::STAT_RESET;
            acc_min_ff <= fsp_pkg::MIN_START;
            acc_sum_ff <= 17'h00000;
        end else if (FRAME.frame_end) begin
            acc_max_ff <= fsp_pkg::STAT_RESET;
            acc_min_ff <= fsp_pkg::MIN_START;
            acc_sum_ff <= 17'h00000;
        end else if (FRAME.pix_valid) begin
            if (FRAME.pix_value > acc_max_ff) acc_max_ff <= FRAME.pix_value;
            if (FRAME.pix_value < acc_min_ff) acc_min_ff <= FRAME.pix_value;
            acc_sum_ff <= acc_sum_ff + {9'h000, FRAME.pix_value};
        end
    end

    // Published values change only at a frame boundary, so reads see one frame.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            surface_quality_ff <= fsp_pkg::STAT_RESET;
            brightest_pixel_ff <= fsp_pkg::STAT_RESET;
            darkest_pixel_ff <= fsp_pkg::STAT_RESET;
            frame_brightness_sum_ff <= fsp_pkg::STAT_RESET;
        end else if (FRAME.frame_end) begin
            surface_quality_ff <= nxt_quality;
            brightest_pixel_ff <= nxt_brightest;
            darkest_pixel_ff <= nxt_darkest;
            frame_brightness_sum_ff <= nxt_sum;
        end
    end

    // ****************************************************************
    // Exposure control and the coherent byte pair.
    // ****************************************************************
    wire logic too_bright = (nxt_brightest > fsp_pkg::BRIGHT_HIGH) | (nxt_sum > fsp_pkg::SUM_HIGH);
    wire logic too_dark = nxt_sum < fsp_pkg::SUM_LOW;

    // A simple bang-bang loop: slow, but it cannot oscillate faster than a frame.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            exposure_ff <= fsp_pkg::EXPOSURE_RESET;
        end else if (FRAME.frame_end) begin
            if (too_bright && exposure_ff > fsp_pkg::EXPOSURE_MIN) begin
                exposure_ff <= exposure_ff - fsp_pkg::EXPOSURE_STEP;
            end else if (too_dark && !too_bright && exposure_ff < fsp_pkg::EXPOSURE_MAX) begin
                exposure_ff <= exposure_ff + fsp_pkg::EXPOSURE_STEP;
            end
        end
    end

    // Reading the high byte freezes the low byte, so the pair belongs together.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            exp_low_snap_ff <= 8'h00;
        end else if (rd_exp_high) begin
            exp_low_snap_ff <= exposure_ff[7:0];
        end
    end

    assign EXPOSURE = exposure_ff;

    // ****************************************************************
    // Pixel dump.
    // ****************************************************************
    logic [8:0] dump_ptr_ff;
    logic dump_active_ff;
    logic dump_grabbed_ff;
    logic dump_ready_ff;
    logic dump_first_ff;

    wire logic grab_hit = FRAME.pix_valid & dump_active_ff & ~dump_ready_ff & ~dump_grabbed_ff
                          & (FRAME.pix_index == dump_ptr_ff);
    wire logic dump_taken = rd_dump & dump_ready_ff;
    wire logic ptr_at_end = dump_ptr_ff == fsp_pkg::LAST_PIXEL;

    // A write restarts the walk; the byte is offered at the end of the frame it came from.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dump_ptr_ff <= fsp_pkg::FIRST_PIXEL;
            dump_active_ff <= 1'b0;
            dump_grabbed_ff <= 1'b0;
            dump_ready_ff <= 1'b0;
            dump_first_ff <= 1'b0;
            dump_byte_ff <= 8'h00;
        end else if (wr_dump) begin
            dump_ptr_ff <= fsp_pkg::FIRST_PIXEL;
            dump_first_ff <= 1'b1;
            dump_active_ff <= 1'b1;
            dump_grabbed_ff <= 1'b0;
            dump_ready_ff <= 1'b0;
        end else begin
            if (grab_hit) begin
                dump_byte_ff <= FRAME.pix_value;
                dump_grabbed_ff <= 1'b1;
            end else if (FRAME.frame_end && dump_grabbed_ff) begin
                dump_ready_ff <= 1'b1;
                dump_grabbed_ff <= 1'b0;
            end
            if (dump_taken) begin
                dump_ready_ff <= 1'b0;
                if (ptr_at_end) begin
                    dump_ptr_ff <= fsp_pkg::FIRST_PIXEL;
                    dump_first_ff <= 1'b1;
                end else begin
                    dump_ptr_ff <= dump_ptr_ff + 9'h001;
                    dump_first_ff <= 1'b0;
                end
            end
        end
    end

    assign DUMP_BYTE_READY = dump_ready_ff;
    assign DUMP_FRAME_START = dump_first_ff;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking chk_clk @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_dump_write;
        wr_dump;
    endsequence

    sequence s_dump_restarted;
        dump_ptr_ff == fsp_pkg::FIRST_PIXEL && dump_first_ff && !dump_ready_ff;
    endsequence

    chk_quality_ceiling: assert property (surface_quality_ff <= 8'ha7)
        else $error("Surface quality above its ceiling.");
    chk_quality_latch: assert property (FRAME.frame_end |=>
        surface_quality_ff == clamp8($past(FRAME.feature_count[8:1]), 8'ha7))
        else $error("Surface quality not taken from the feature count.");
    chk_bright_range: assert property (brightest_pixel_ff <= 8'hfe)
        else $error("Brightest pixel out of range.");
    chk_dark_range: assert property (darkest_pixel_ff <= 8'hfe)
        else $error("Darkest pixel out of range.");
    chk_sum_ceiling: assert property (frame_brightness_sum_ff <= 8'hf0)
        else $error("Brightness sum above its ceiling.");
    chk_dump_restart: assert property (s_dump_write |=> s_dump_restarted)
        else $error("Dump write did not restart the walk.");
    chk_ready_hold: assert property (dump_ready_ff && !rd_dump && !wr_dump |=>
        dump_ready_ff && $stable(dump_byte_ff))
        else $error("Dump byte changed before it was read.");
    chk_ready_cause: assert property ($rose(dump_ready_ff) |-> $past(FRAME.frame_end))
        else $error("Ready flag rose outside a frame end.");
    chk_ptr_step: assert property (dump_taken && !ptr_at_end |=>
        dump_ptr_ff == $past(dump_ptr_ff) + 9'h001 && !dump_first_ff)
        else $error("Pointer did not advance after a dump read.");
    chk_ptr_wrap: assert property (dump_taken && ptr_at_end |=>
        dump_ptr_ff == 9'h000 && dump_first_ff)
        else $error("Pointer did not wrap after the last pixel.");
    chk_exp_pair: assert property (rd_exp_high |=>
        exp_low_snap_ff == $past(exposure_ff[7:0]))
        else $error("Low exposure byte not frozen by the high read.");

    // Range, latch and quiet-cycle checks: a published value moving off a frame end would tear a read.
    sequence s_frame_closed;
        FRAME.frame_end;
    endsequence

    chk_exp_bounds: assert property (exposure_ff >= fsp_pkg::EXPOSURE_MIN
        && exposure_ff <= fsp_pkg::EXPOSURE_MAX)
        else $error("Exposure left its control range.");
    chk_exp_quiet: assert property (!FRAME.frame_end |=> $stable(exposure_ff))
        else $error("Exposure moved outside a frame end.");
    chk_sum_latch: assert property (s_frame_closed |=>
        frame_brightness_sum_ff == clamp8($past(acc_sum_ff[16:fsp_pkg::SUM_SHIFT]),
        fsp_pkg::SUM_LIMIT))
        else $error("Brightness sum not taken from the frame total.");
    chk_stats_hold: assert property (!FRAME.frame_end |=>
        $stable(brightest_pixel_ff) && $stable(darkest_pixel_ff))
        else $error("Pixel extremes moved outside a frame end.");
    chk_dump_load: assert property (rd_dump |=>
        shift_out_ff == $past(dump_byte_ff))
        else $error("Dump read did not present the held byte.");
    chk_idle_read: assert property (rd_dump && !dump_ready_ff |=>
        $stable(dump_ptr_ff))
        else $error("Pointer moved on a read without a ready byte.");
    chk_first_hold: assert property (dump_first_ff && !dump_taken && !wr_dump |=>
        dump_first_ff)
        else $error("First-pixel flag dropped without a dump read.");
    chk_pair_hold: assert property (!rd_exp_high |=> $stable(exp_low_snap_ff))
        else $error("Low exposure snapshot moved without a high read.");

endmodule

// File: test/fsp_ctrl_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Serial port master standing in for the external controller.
// ****************************************************************
module fsp_ctrl_model (
    input wire logic clk,
    output logic ncs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // Deselected with the clock parked high, as mode 3 requires.
    initial begin
        ncs_n = 1'b1;
        sclk = 1'b1;
        mosi = 1'b0;
    end

    // Four system clocks per half period keep the edges above the sampling minimum.
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Address byte then data byte, MSB first; a data bit is taken just before its falling edge.
    task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wd,
                          output logic [7:0] rd);
        logic [15:0] tx;
        tx = {wr, addr, wd};
        @(posedge clk);
        #1;
        ncs_n = 1'b0;
        half();
        for (int i = 15; i >= 0; i--) begin
            if (i < 8) rd[i] = miso_oe ? miso : 1'bx;
            sclk = 1'b0;
            mosi = tx[i];
            half();
            sclk = 1'b1;
            half();
        end
        ncs_n = 1'b1;
        // The released data line shows the opposite bit so nothing stale looks valid.
        mosi = ~mosi;
        half();
    endtask
endmodule

// File: test/tb_frame_statistics_pixel_dump.sv
`timescale 1ns/10ps

`define CHK(act, exp) begin \
    n_compared++; \
    if ((act) !== (exp)) begin \
        bad_count++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, act, exp); \
    end \
end

module tb_frame_statistics_pixel_dump;
    logic clk;
    logic nrst;
    logic ncs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    fsp_pkg::fsp_frame_t frame;
    logic [15:0] exposure;
    logic dump_ready;
    logic dump_first;
    int bad_count;
    int n_compared;
    integer seed;
    logic [7:0] pix [484];
    logic [7:0] rd;
    logic [7:0] val;
    logic [8:0] ptr;

    fsp_frame_stats dut_u (.CLK(clk), .NRST(nrst), .NCS_N(ncs_n), .SCLK(sclk), .MOSI(mosi),
        .MISO(miso), .MISO_OE(miso_oe), .FRAME(frame), .EXPOSURE(exposure),
        .DUMP_BYTE_READY(dump_ready), .DUMP_FRAME_START(dump_first));
    fsp_ctrl_model mst_u (.clk(clk), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe));

    // ****************************************************************
    // Clock, helpers and expectations.
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Saturation that every statistic register applies.
    function automatic logic [7:0] clip(input logic [16:0] v, input logic [7:0] lim);
        return (v > 17'(lim)) ? lim : v[7:0];
    endfunction

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
        mst_u.access(1'b0, addr, 8'h00, rd);
        `CHK(rd, exp)
        `CHK(miso_oe, 1'b0)
    endtask

    // Pixels go out back to back; the end pulse follows on its own cycle.
    task automatic frame_out(input int first, input int cnt, input logic [8:0] fc);
        int k;
        for (int j = 0; j < cnt; j++) begin
            k = (first + j) % 484;
            tick();
            frame = {1'b1, 9'(k), pix[k], 1'b0, fc};
        end
        tick();
        frame = {1'b0, 9'h000, 8'h00, 1'b1, fc};
        tick();
        frame.frame_end = 1'b0;
    endtask

    task automatic stats_frame(input logic [8:0] fc);
        logic [7:0] mx;
        logic [7:0] mn;
        logic [16:0] sm;
        mx = 8'h00;
        mn = 8'hff;
        sm = '0;
        for (int i = 0; i < 484; i++) begin
            mx = (pix[i] > mx) ? pix[i] : mx;
            mn = (pix[i] < mn) ? pix[i] : mn;
            sm = sm + 17'(pix[i]);
        end
        frame_out(0, 484, fc);
        repeat (2) tick();
        rd_chk(fsp_pkg::ADDR_SURFACE_QUALITY, clip(17'(fc[8:1]), 8'ha7));
        rd_chk(fsp_pkg::ADDR_BRIGHTEST_PIXEL, clip(17'(mx), 8'hfe));
        rd_chk(fsp_pkg::ADDR_DARKEST_PIXEL, clip(17'(mn), 8'hfe));
        rd_chk(fsp_pkg::ADDR_FRAME_BRIGHTNESS_SUM, clip(17'(sm[16:9]), 8'hf0));
    endtask

    task automatic summarize();
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang costs one mismatch and still reaches the verdict.
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        summarize();
    end

    // Main sequence: reset, statistics frames, then a full dump with one wrap.
    initial begin
        seed = 4844;
        bad_count = 0;
        n_compared = 0;
        nrst = 1'b0;
        frame = '0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) tick();
        `CHK(exposure, 16'h0100)
        rd_chk(fsp_pkg::ADDR_EXPOSURE_HIGH, 8'h01);
        rd_chk(fsp_pkg::ADDR_EXPOSURE_LOW, 8'h00);
        rd_chk(7'h7f, 8'h00);
        for (int i = 0; i < 484; i++) pix[i] = 8'h00;
        stats_frame(9'h000);
        `CHK(exposure, 16'h0110)
        rd_chk(fsp_pkg::ADDR_EXPOSURE_HIGH, 8'h01);
        rd_chk(fsp_pkg::ADDR_EXPOSURE_LOW, 8'h10);
        mst_u.access(1'b1, fsp_pkg::ADDR_SURFACE_QUALITY, 8'haa, rd);
        rd_chk(fsp_pkg::ADDR_SURFACE_QUALITY, 8'h00);
        for (int i = 0; i < 484; i++) pix[i] = 8'hff;
        stats_frame(9'h1ff);
        `CHK(exposure, 16'h0100)
        for (int f = 0; f < 3; f++) begin
            for (int i = 0; i < 484; i++) pix[i] = 8'($random(seed));
            stats_frame(9'($random(seed)));
        end
        mst_u.access(1'b1, fsp_pkg::ADDR_FRAME_DUMP_PORT, 8'($random(seed)), rd);
        tick();
        `CHK({dump_ready, dump_first}, 2'b01)
        ptr = 9'h000;
        for (int n = 0; n < 486; n++) begin
            `CHK(dump_ready, 1'b0)
            val = 8'($random(seed));
            pix[ptr] = val;
            pix[(int'(ptr) + 483) % 484] = ~val;
            frame_out((int'(ptr) + 483) % 484, 2, 9'h000);
            for (int w = 0; w < 20 && dump_ready !== 1'b1; w++) tick();
            `CHK(dump_ready, 1'b1)
            rd_chk(fsp_pkg::ADDR_FRAME_DUMP_PORT, val);
            ptr = (ptr == 9'd483) ? 9'h000 : ptr + 9'h001;
            `CHK(dump_first, ptr == 9'h000)
            if (n == 5) begin
                rd_chk(fsp_pkg::ADDR_FRAME_DUMP_PORT, val);
            end
        end
        summarize();
    end
endmodule
